// ===== design/icft_pkg.sv
// Package with constants and carrier types of the serial configuration target.
package icft_pkg;

    // Register map.
    localparam logic [7:0] GENERAL_CONTROL_OFFSET = 8'h0A;
    localparam logic [7:0] DISPLAY_GAIN_OFFSET_A = 8'h10;
    localparam logic [7:0] DISPLAY_GAIN_OFFSET_B = 8'h11;
    localparam logic [7:0] GENERAL_CONTROL_RESET = 8'h01;
    localparam logic [7:0] DISPLAY_GAIN_RESET = 8'h00;
    localparam logic [7:0] POINTER_RESET = 8'h00;

    // Field positions of the general control register.
    localparam int GAIN_SELECT_BIT = 4;
    localparam int ENABLE_SOURCE_BIT = 3;
    localparam int FLIP_BIT = 2;
    localparam int LANE_LSB = 0;

    // Lane configuration codes.
    localparam logic [1:0] LANE_OFF = 2'h0;
    localparam logic [1:0] LANE_USB_ONLY = 2'h1;
    localparam logic [1:0] LANE_DISPLAY_FOUR = 2'h2;
    localparam logic [1:0] LANE_DISPLAY_TWO_USB = 2'h3;

    // Strap levels: 0, pulled low through a resistor, floating, 1.
    localparam logic [1:0] STRAP_ZERO = 2'h0;
    localparam logic [1:0] STRAP_RES = 2'h1;
    localparam logic [1:0] STRAP_FLOAT = 2'h2;
    localparam logic [1:0] STRAP_ONE = 2'h3;
    localparam logic [4:0] ADDR_HIGH_ZERO = 5'h11;
    localparam logic [4:0] ADDR_HIGH_RES = 5'h08;
    localparam logic [4:0] ADDR_HIGH_FLOAT = 5'h04;
    localparam logic [4:0] ADDR_HIGH_ONE = 5'h03;

    // Bit counter values.
    localparam logic [3:0] BIT_COUNT_RESET = 4'h0;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    typedef enum {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
        ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK, ST_WAIT
    } icft_phase_type;

    // Pin samples after the synchroniser.
    typedef struct packed {
        logic scl;
        logic sda;
    } icft_bus_type;

    // Block control outputs.
    typedef struct packed {
        logic gain_register_select;
        logic display_enable;
        logic orientation_flip_select;
        logic [1:0] lane_config_field;
        logic usb_enable;
        logic [3:0] display_lane_gain;
    } icft_ctrl_type;

endpackage : icft_pkg

// ===== design/icft_target.sv
// Two-wire configuration target with the general control register.
// Contract
// - Config access over serial clock pin and bidirectional data pin.
// - 7-bit address from two four-level straps, high five and low two bits.
// - Write: start, address with direction zero; address byte acknowledged.
// - Pointer byte follows address, MSB first, acknowledged, used as target.
// - Each written data byte acknowledged and stored in addressed register.
// - Read: start, address with direction one; address byte acknowledged.
// - Read returns MSB first from 00h or last read plus one.
// - Pointer write before read makes the read start at that pointer.
// - After each sent byte wait for acknowledge; continue only on acknowledge.
// - Pointer-only write sets start of later reads; both bytes acknowledged.
// - Set fields set by one, clear by one, zero writes change nothing; the code writes each field directly, so zero clears it.
// - General control at 0x0A resets to 01; bits 7:5 read zero.
// - Bit 4 selects gain from straps (0) or registers (1).
// - Bit 3 selects display enable from lane high bit or pin.
// - Bit 2 is orientation flip select, reset zero.
// - Bits 1:0 select lane configuration, reset 01.
// - With bit 4 clear, display gain fields read the display straps.
`timescale 1ns/1ps
`default_nettype none

module icft_target (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic reset,
    // Serial pins.
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Strap and control pins.
    input wire logic [1:0] address_strap_high,
    input wire logic [1:0] address_strap_low,
    input wire logic [1:0] display_gain_straps,
    input wire logic display_enable_pin,
    // Control outputs.
    output icft_pkg::icft_ctrl_type ctrl
);

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        icft_pkg::icft_bus_type sync1;
        icft_pkg::icft_bus_type sync2;
        icft_pkg::icft_bus_type prev;
        icft_pkg::icft_phase_type phase;
        logic [3:0] bit_count;
        logic [7:0] shift;
        logic [7:0] pointer;
        logic [7:0] general;
        logic [7:0] gain_a;
        logic [7:0] gain_b;
        logic [1:0] strap_latch;
        logic [6:0] own_addr;
        logic strap_taken;
        logic sda_drive;
        logic de_meta;
        logic de_sync;
        icft_pkg::icft_ctrl_type ctrl;
    } icft_state_type;

    icft_state_type state_q;
    icft_state_type state_d;

    // Maps the upper strap level to the high five address bits.
    function automatic logic [4:0] high_bits(input logic [1:0] level);
        case (level)
            icft_pkg::STRAP_ZERO: high_bits = icft_pkg::ADDR_HIGH_ZERO;
            icft_pkg::STRAP_RES: high_bits = icft_pkg::ADDR_HIGH_RES;
            icft_pkg::STRAP_FLOAT: high_bits = icft_pkg::ADDR_HIGH_FLOAT;
            default: high_bits = icft_pkg::ADDR_HIGH_ONE;
        endcase
    endfunction

    // Read value of a register, reserved bits and holes as zero.
    function automatic logic [7:0] read_reg(input icft_state_type s,
                                            input logic [7:0] idx);
        logic [7:0] strap_both;
        strap_both = {2'h0, s.strap_latch, 2'h0, s.strap_latch};
        read_reg = 8'h00;
        if (idx == icft_pkg::GENERAL_CONTROL_OFFSET) begin
            read_reg = {3'h0, s.general[4:0]};
        end
        else if (idx == icft_pkg::DISPLAY_GAIN_OFFSET_A) begin
            read_reg = s.general[icft_pkg::GAIN_SELECT_BIT] ? s.gain_a
                                                            : strap_both;
        end else if (idx == icft_pkg::DISPLAY_GAIN_OFFSET_B) begin
            read_reg = s.general[icft_pkg::GAIN_SELECT_BIT] ? s.gain_b
                                                            : strap_both;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic [7:0] read_now;

    always_comb begin
        scl_rise = state_q.sync2.scl && !state_q.prev.scl;
        scl_fall = !state_q.sync2.scl && state_q.prev.scl;
        start_seen = state_q.sync2.scl && state_q.prev.scl &&
                     !state_q.sync2.sda && state_q.prev.sda;
        stop_seen = state_q.sync2.scl && state_q.prev.scl &&
                    state_q.sync2.sda && !state_q.prev.sda;
        read_now = read_reg(state_q, state_q.pointer);
    end

    always_comb begin
        state_d = state_q;
        state_d.sync1 = '{scl: scl_in, sda: sda_in};
        state_d.sync2 = state_q.sync1;
        state_d.prev = state_q.sync2;
        // Two-stage synchroniser for the display enable pin.
        state_d.de_meta = display_enable_pin;
        state_d.de_sync = state_q.de_meta;

        if (!state_q.strap_taken) begin
            state_d.strap_taken = 1'b1;
            state_d.own_addr = {high_bits(address_strap_high),
                                address_strap_low};
            state_d.strap_latch = display_gain_straps;
        end

        if (start_seen) begin
            state_d.phase = icft_pkg::ST_ADDR;
            state_d.bit_count = icft_pkg::BIT_COUNT_RESET;
            state_d.sda_drive = 1'b0;
        end else if (stop_seen) begin
            state_d.phase = icft_pkg::ST_IDLE;
            state_d.sda_drive = 1'b0;
        end else begin
            case (state_q.phase)
                icft_pkg::ST_ADDR, icft_pkg::ST_PTR, icft_pkg::ST_WDATA: begin
                    if (scl_rise) begin
                        state_d.shift = {state_q.shift[6:0],
                                         state_q.sync2.sda};
                        state_d.bit_count = state_q.bit_count + 4'h1;
                    end
                    if (scl_fall &&
                        state_q.bit_count == icft_pkg::BITS_PER_BYTE) begin
                        state_d.bit_count = icft_pkg::BIT_COUNT_RESET;
                        if (state_q.phase == icft_pkg::ST_ADDR) begin
                            if (state_q.shift[7:1] == state_q.own_addr) begin
                                state_d.sda_drive = 1'b1;
                                state_d.phase = icft_pkg::ST_ADDR_ACK;
                            end else begin
                                state_d.phase = icft_pkg::ST_WAIT;
                            end
                        end else if (state_q.phase == icft_pkg::ST_PTR) begin
                            state_d.pointer = state_q.shift;
                            state_d.sda_drive = 1'b1;
                            state_d.phase = icft_pkg::ST_PTR_ACK;
                        end else begin
                            if (state_q.pointer ==
                                icft_pkg::GENERAL_CONTROL_OFFSET) begin
                                state_d.general = {3'h0, state_q.shift[4:0]};
                            end else if (state_q.pointer ==
                                         icft_pkg::DISPLAY_GAIN_OFFSET_A) begin
                                state_d.gain_a = state_q.shift;
                            end else if (state_q.pointer ==
                                         icft_pkg::DISPLAY_GAIN_OFFSET_B) begin
                                state_d.gain_b = state_q.shift;
                            end
                            state_d.pointer = state_q.pointer + 8'h01;
                            state_d.sda_drive = 1'b1;
                            state_d.phase = icft_pkg::ST_WDATA_ACK;
                        end
                    end
                end
                icft_pkg::ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        if (state_q.shift[0]) begin
                            state_d.shift = read_now;
                            state_d.sda_drive = !read_now[7];
                            state_d.phase = icft_pkg::ST_RDATA;
                        end else begin
                            state_d.sda_drive = 1'b0;
                            state_d.phase = icft_pkg::ST_PTR;
                        end
                    end
                end
                icft_pkg::ST_PTR_ACK, icft_pkg::ST_WDATA_ACK: begin
                    // Pointer kept; further bytes are data.
                    if (scl_fall) begin
                        state_d.sda_drive = 1'b0;
                        state_d.phase = icft_pkg::ST_WDATA;
                    end
                end
                icft_pkg::ST_RDATA: begin
                    if (scl_fall) begin
                        state_d.bit_count = state_q.bit_count + 4'h1;
                        if (state_q.bit_count == 4'h7) begin
                            state_d.sda_drive = 1'b0;
                            state_d.phase = icft_pkg::ST_RDATA_ACK;
                        end else begin
                            state_d.shift = {state_q.shift[6:0], 1'b0};
                            state_d.sda_drive = !state_q.shift[6];
                        end
                    end
                end
                icft_pkg::ST_RDATA_ACK: begin
                    if (scl_rise) begin
                        state_d.pointer = state_q.pointer + 8'h01;
                        if (state_q.sync2.sda) begin
                            state_d.phase = icft_pkg::ST_WAIT;
                        end else begin
                            state_d.bit_count = icft_pkg::BITS_PER_BYTE;
                        end
                    end
                    if (scl_fall &&
                        state_q.bit_count == icft_pkg::BITS_PER_BYTE) begin
                        state_d.bit_count = icft_pkg::BIT_COUNT_RESET;
                        state_d.shift = read_now;
                        state_d.sda_drive = !read_now[7];
                        state_d.phase = icft_pkg::ST_RDATA;
                    end
                end
                icft_pkg::ST_IDLE, icft_pkg::ST_WAIT: begin
                    state_d.sda_drive = 1'b0;
                end
                default: begin
                    state_d.phase = icft_pkg::ST_IDLE;
                end
            endcase
        end

        state_d.ctrl.gain_register_select =
            state_q.general[icft_pkg::GAIN_SELECT_BIT];
        state_d.ctrl.display_lane_gain =
            state_q.general[icft_pkg::GAIN_SELECT_BIT] ?
            state_q.gain_a[7:4] : {2'h0, state_q.strap_latch};
        state_d.ctrl.display_enable =
            state_q.general[icft_pkg::ENABLE_SOURCE_BIT] ?
            state_q.de_sync :
            state_q.general[icft_pkg::LANE_LSB + 1];
        state_d.ctrl.orientation_flip_select =
            state_q.general[icft_pkg::FLIP_BIT];
        state_d.ctrl.lane_config_field =
            state_q.general[icft_pkg::LANE_LSB +: 2];
        state_d.ctrl.usb_enable =
            state_q.general[icft_pkg::LANE_LSB +: 2] ==
                icft_pkg::LANE_USB_ONLY ||
            state_q.general[icft_pkg::LANE_LSB +: 2] ==
                icft_pkg::LANE_DISPLAY_TWO_USB;
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state_q <= '0;
            state_q.sync1 <= '{scl: 1'b1, sda: 1'b1};
            state_q.sync2 <= '{scl: 1'b1, sda: 1'b1};
            state_q.prev <= '{scl: 1'b1, sda: 1'b1};
            state_q.phase <= icft_pkg::ST_IDLE;
            state_q.pointer <= icft_pkg::POINTER_RESET;
            state_q.general <= icft_pkg::GENERAL_CONTROL_RESET;
            state_q.gain_a <= icft_pkg::DISPLAY_GAIN_RESET;
            state_q.gain_b <= icft_pkg::DISPLAY_GAIN_RESET;
            state_q.ctrl.lane_config_field <= icft_pkg::LANE_USB_ONLY;
            state_q.ctrl.usb_enable <= 1'b1;
        end else begin
            state_q <= state_d;
        end
    end

    // Open-drain data: only ever drives low.
    assign sda_out = 1'b0;
    assign sda_oe = state_q.sda_drive;
    assign ctrl = state_q.ctrl;

endmodule : icft_target
`default_nettype wire

// ===== verif/icft_target_sva.sv
// Checker of the configuration target's pin and control behaviour.
`timescale 1ns/1ps
`default_nettype none

module icft_target_sva (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic reset,
    // Serial pins.
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    // Strap and control pins.
    input wire logic [1:0] address_strap_high,
    input wire logic [1:0] address_strap_low,
    input wire logic [1:0] display_gain_straps,
    input wire logic display_enable_pin,
    // Control outputs.
    input wire icft_pkg::icft_ctrl_type ctrl
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    sda_low_a: assert property (!sda_out)
        else $error("data output not low");
    reset_quiet_a: assert property (disable iff (1'b0) reset |=> !sda_oe)
        else $error("data driven after reset");
    reset_ctrl_a: assert property (disable iff (1'b0) reset |=>
        ctrl.lane_config_field == 2'h1 && ctrl.usb_enable &&
        !ctrl.display_enable && !ctrl.orientation_flip_select &&
        !ctrl.gain_register_select)
        else $error("control outputs wrong after reset");
    usb_lane_a: assert property (ctrl.usb_enable == ctrl.lane_config_field[0])
        else $error("usb enable does not follow lane code");
    display_src_a: assert property ((ctrl.display_enable !=
        ctrl.lane_config_field[1]) |->
        ctrl.display_enable == $past(display_enable_pin, 3))
        else $error("display enable from neither source");
    strap_gain_a: assert property (!ctrl.gain_register_select &&
        !$past(reset) && !$past(reset, 2) && !$past(reset, 3) |->
        ctrl.display_lane_gain == {2'h0, display_gain_straps})
        else $error("display gain does not show straps");
    oe_scl_low_a: assert property ((sda_oe != $past(sda_oe)) |-> !scl_in)
        else $error("data drive changed while clock high");
    drive_hold_a: assert property ($rose(sda_oe) |-> sda_oe [*4])
        else $error("data drive too short");
    start_free_a: assert property (scl_in && $fell(sda_in) |=> !sda_oe [*4])
        else $error("data driven after start");
endmodule // icft_target_sva

bind icft_target icft_target_sva chk_u (.core_clk(core_clk), .reset(reset),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .address_strap_high(address_strap_high),
    .address_strap_low(address_strap_low),
    .display_gain_straps(display_gain_straps),
    .display_enable_pin(display_enable_pin), .ctrl(ctrl));

`default_nettype wire

// ===== verif/icft_ctrl_model.sv
// Behavioural two-wire bus controller that faces the target in the bench.
`timescale 1ns/1ps
`default_nettype none

module icft_ctrl_model (
    // Bus lines.
    output logic scl,
    output logic sda_pull,
    input wire logic sda,
    // Observed results.
    output logic [7:0] obs_data,
    output logic obs_valid
);
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
        obs_data = 8'h00;
        obs_valid = 1'b0;
    end

    // One 125 ns bit: data moves mid-low, is sampled mid-high.
    task automatic slot(input logic drive_low, output logic seen);
        scl = 1'b0;
        #40 sda_pull = drive_low;
        #35 scl = 1'b1;
        #25 seen = sda;
        #25;
    endtask

    task automatic post(input logic [7:0] d);
        obs_data = d;
        obs_valid = 1'b1;
        #1 obs_valid = 1'b0;
    endtask

    task automatic start();
        sda_pull = 1'b1;
        #50;
    endtask

    task automatic stop();
        scl = 1'b0;
        #40 sda_pull = 1'b1;
        #35 scl = 1'b1;
        #40 sda_pull = 1'b0;
        #60;
    endtask

    task automatic send_byte(input logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            slot(!b[i], s);
        end
        slot(1'b0, s);
        post({7'h00, s});
    endtask

    task automatic recv_byte(input logic more);
        logic s;
        logic [7:0] d;
        for (int i = 7; i >= 0; i--) begin
            slot(1'b0, d[i]);
        end
        slot(more, s);
        post(d);
    endtask
endmodule // icft_ctrl_model

`default_nettype wire

// ===== verif/icft_target_tb.sv
// Self-checking bench of the two-wire configuration target.
`timescale 1ns/1ps
`default_nettype none

module icft_target_tb;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic scl, sda_pull, sda_line, sda_out, sda_oe, obs_valid, de_pin;
    logic [1:0] st_hi, st_lo, st_dg;
    logic [7:0] obs_data, v, seen, want, g;
    logic [6:0] dev;
    logic [4:0] hi_tab [4] = '{5'h11, 5'h08, 5'h04, 5'h03};
    logic [7:0] exp_q[$];
    int n_fail = 0;
    int checks_done = 0;
    icft_pkg::icft_ctrl_type ctrl;

    always #5 core_clk = ~core_clk;
    assign sda_line = !(sda_oe && !sda_out) && !sda_pull;

    icft_target dut_u (.core_clk(core_clk), .reset(reset), .scl_in(scl),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
        .address_strap_high(st_hi), .address_strap_low(st_lo),
        .display_gain_straps(st_dg), .display_enable_pin(de_pin),
        .ctrl(ctrl));
    icft_ctrl_model m_u (.scl(scl), .sda_pull(sda_pull), .sda(sda_line),
        .obs_data(obs_data), .obs_valid(obs_valid));

    task automatic check(input string name, input logic [7:0] s, e);
        checks_done++;
        if (s !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", name, e, s);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic addr(input logic rd, input logic ok);
        m_u.start();
        exp_q.push_back({7'h00, !ok});
        m_u.send_byte({ok ? dev : ~dev, rd});
    endtask

    task automatic wr(input logic [7:0] d[$]);
        addr(1'b0, 1'b1);
        foreach (d[i]) begin
            exp_q.push_back(8'h00);
            m_u.send_byte(d[i]);
        end
        m_u.stop();
    endtask

    task automatic rd(input logic [7:0] e[$]);
        addr(1'b1, 1'b1);
        foreach (e[i]) begin
            exp_q.push_back(e[i]);
            m_u.recv_byte(i < e.size() - 1);
        end
        m_u.stop();
    endtask

    task automatic chk_ctrl(input logic [7:0] w);
        repeat (10) @(negedge core_clk);
        seen = {2'h0, ctrl.gain_register_select, ctrl.display_enable,
            ctrl.orientation_flip_select, ctrl.lane_config_field,
            ctrl.usb_enable};
        want = {2'h0, w[4], w[3] ? de_pin : w[1], w[2], w[1:0], w[0]};
        check("ctrl", seen, want);
        want = w[4] ? {4'h0, g[7:4]} : {6'h0, st_dg};
        check("gain", {4'h0, ctrl.display_lane_gain}, want);
    endtask

    always @(posedge obs_valid) begin
        check("serial", obs_data, exp_q.pop_front());
    end

    initial begin
        void'($urandom(24612));
        st_hi = 2'($urandom);
        st_lo = 2'($urandom);
        st_dg = 2'($urandom);
        de_pin = 1'($urandom);
        dev = {hi_tab[st_hi], st_lo};
        repeat (5) @(negedge core_clk);
        reset = 1'b0;
        repeat (6) @(negedge core_clk);
        chk_ctrl(8'h01);
        addr(1'b0, 1'b0);
        m_u.stop();
        wr('{8'h08});
        rd('{8'h00});
        rd('{8'h00, 8'h01, 8'h00});
        g = 8'($urandom);
        wr('{8'h10, g});
        for (int i = 0; i < 4; i++) begin
            @(negedge core_clk);
            v = {3'($urandom), 3'($urandom), 2'(i)};
            de_pin = 1'($urandom);
            wr('{8'h09, 8'($urandom), v});
            chk_ctrl(v);
            wr('{8'h0A});
            rd('{v & 8'h1F});
        end
        wr('{8'h0A, 8'h10});
        wr('{8'h10});
        rd('{g});
        wr('{8'h0A, 8'h01});
        wr('{8'h10});
        rd('{{2'h0, st_dg, 2'h0, st_dg}});
        check("pending", 8'(exp_q.size()), 8'h00);
        conclude();
    end

    initial begin
        #600us;
        n_fail++;
        conclude();
    end
endmodule // icft_target_tb

`default_nettype wire
